// ### rtl/lpmc_defs.svh
// Offsets, field positions, reset values and timing counts of the power mode controller.
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH

// ==========================================
// Register byte offsets
`define LPMC_A_CTRL      12'h000
`define LPMC_A_STATUS    12'h004
`define LPMC_A_WDT_LOAD  12'h008
`define LPMC_A_WDT_KICK  12'h00c
`define LPMC_A_PLL_CFG   12'h010
`define LPMC_A_IRQ_STAT  12'h014
`define LPMC_A_IRQ_MASK  12'h018

// ==========================================
// Control register fields
`define LPMC_C_SUSP      0
`define LPMC_C_STBY      1
`define LPMC_C_CPURST    2
`define LPMC_C_DEVRST    3
`define LPMC_C_CFG_LO    4
`define LPMC_C_CFG_HI    9
`define LPMC_CFG_RST     6'h00

// ==========================================
// Pin indices in the synchronised wake vector
`define LPMC_P_DP        0
`define LPMC_P_DM        1
`define LPMC_P_SS        2
`define LPMC_P_VBUS      3
`define LPMC_P_CTS       4
`define LPMC_P_RSTN      5
`define LPMC_P_VDD       6
`define LPMC_P_SLOW      7
`define LPMC_PIN_RST     8'h60

// ==========================================
// Wake source codes and interrupt bits
`define LPMC_W_NONE      3'h0
`define LPMC_W_DP        3'h1
`define LPMC_W_DM        3'h2
`define LPMC_W_SS        3'h3
`define LPMC_W_VBUS      3'h4
`define LPMC_W_CTS       3'h5
`define LPMC_W_RST       3'h6
`define LPMC_W_WDT       3'h7
`define LPMC_I_WAKE      0
`define LPMC_I_WDT       1
`define LPMC_I_LOST      2

// ==========================================
// Timing and clock figures
`define LPMC_PCLK_HZ     10000000
`define LPMC_WDT_HZ      32768
`define LPMC_WDT_DIV     (`LPMC_PCLK_HZ / `LPMC_WDT_HZ)
`define LPMC_WDT_LOAD_RST 16'h7fff
`define LPMC_PLL_OUT_MHZ 10'h190
`define LPMC_REF_MIN_MHZ 6'h06
`define LPMC_REF_MAX_MHZ 6'h28
`define LPMC_REF_RST_MHZ 6'h13

`endif

// ### rtl/lpmc_pkg.sv
// Types shared by the power mode controller.
package lpmc_pkg;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_SUSPEND,
        ST_STANDBY,
        ST_PWRDN
    } lpmc_mode_t;

    typedef struct packed {
        logic slow_clk;
        logic vdd_good;
        logic reset_pin_n;
        logic cts;
        logic vbus;
        logic ss_resume;
        logic dm;
        logic dp;
    } lpmc_pins_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic pll_en;
        logic ss_phy_en;
        logic ss_u3;
        logic xcvr_en;
        logic core_pwr_en;
        logic io_hold;
        logic gpio_cfg_keep;
        logic ram_retain;
        logic buf_retain;
    } lpmc_pwr_t;

endpackage

// ### rtl/lpmc_ctrl.sv
// Low power mode controller: mode sequencer, wake logic, watchdog and APB registers.
//
// Summary of operation
// [RULE1] Normal mode runs processor clock and all PLLs.
// [RULE2] Suspend keeps only the SuperSpeed PHY alive in U3; other clocks stop.
// [RULE3] Suspend holds every I/O pin at its previous state.
// [RULE4] Suspend keeps registers, buffers and RAM unchanged.
// [RULE5] Firmware completes all transactions before asking for suspend.
// [RULE6] Non-reset wake from suspend resumes without resetting the program counter.
// [RULE7] Suspend exits on D+/D-, SS resume, VBUS, CTS level, or reset pin.
// [RULE8] Standby keeps registers and RAM; buffer data may be lost.
// [RULE9] The controller reads needed buffer data before asking for standby.
// [RULE10] Standby exits on VBUS, CTS level or reset pin; core restarts.
// [RULE11] Standby turns off PLL, transceiver and core; GPIO setup kept.
// [RULE12] Firmware or external processor enters standby or suspend by register write.
// [RULE13] Core supply loss powers down and loses all state until restored.
// [RULE14] Watchdog can interrupt, wake from standby, and reset the core.
// [RULE15] Watchdog counts a 32 kHz clock, internal or from a pin.
// [RULE16] Firmware can disable the watchdog entirely.
// [RULE17] PLL multiplier is chosen from the reference frequency.
// [RULE18] CPU soft reset restarts core; device soft reset equals reset pin.
// [RULE19] The last wake source is readable in a status register.
`include "lpmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module lpmc_ctrl (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Wake and supply pins
    input  wire lpmc_pkg::lpmc_pins_t pins_i,
    // Power controls, resets, PLL multiplier and interrupt
    output lpmc_pkg::lpmc_pwr_t    pwr_o,
    output logic                   cpu_reset_o,
    output logic                   dev_reset_o,
    output logic [7:0]             pll_mult_o,
    output logic                   irq_o
);
    import lpmc_pkg::*;

    // ==========================================
    // Pin synchronisers
    // A change is accepted only once stages two and three agree.
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] pin_q;
    logic [7:0] prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q   <= `LPMC_PIN_RST;
            s2_q   <= `LPMC_PIN_RST;
            s3_q   <= `LPMC_PIN_RST;
            pin_q  <= `LPMC_PIN_RST;
            prev_q <= `LPMC_PIN_RST;
        end else begin
            s1_q   <= pins_i;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            pin_q  <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
            prev_q <= pin_q;
        end
    end

    // ==========================================
    // Register state
    lpmc_mode_t  mode_q;
    lpmc_mode_t  mode_d;
    lpmc_pwr_t   pwr_q;
    logic [5:0]  cfg_q;
    logic [15:0] wdt_load_q;
    logic [15:0] wdt_cnt_q;
    logic [8:0]  div_q;
    logic [5:0]  ref_q;
    logic [7:0]  mult_q;
    logic        pll_err_q;
    logic [2:0]  wake_src_q;
    logic [2:0]  wake_code;
    logic [2:0]  irq_stat_q;
    logic [2:0]  irq_mask_q;
    logic [2:0]  irq_set;
    logic        cpu_rst_q;
    logic        dev_rst_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    logic cts_pol;
    logic wdt_en;
    logic wdt_int_en;
    logic wdt_wake_en;
    logic wdt_rst_en;
    logic wdt_ext;
    assign cts_pol     = cfg_q[0];
    assign wdt_en      = cfg_q[1];
    assign wdt_int_en  = cfg_q[2];
    assign wdt_wake_en = cfg_q[3];
    assign wdt_rst_en  = cfg_q[4];
    assign wdt_ext     = cfg_q[5];

    // ==========================================
    // APB decode
    logic apb_setup;
    logic apb_wr;
    logic mapped;
    logic wr_ctrl;
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite && !pslverr_q;
    assign wr_ctrl   = apb_wr && paddr == `LPMC_A_CTRL;
    assign mapped    = paddr == `LPMC_A_CTRL || paddr == `LPMC_A_STATUS
                    || paddr == `LPMC_A_WDT_LOAD || paddr == `LPMC_A_WDT_KICK
                    || paddr == `LPMC_A_PLL_CFG || paddr == `LPMC_A_IRQ_STAT
                    || paddr == `LPMC_A_IRQ_MASK;

    logic susp_req;
    logic stby_req;
    logic cpu_srst;
    logic dev_srst;
    assign susp_req = wr_ctrl && pwdata[`LPMC_C_SUSP];   // RULE12
    assign stby_req = wr_ctrl && pwdata[`LPMC_C_STBY];   // RULE12
    assign cpu_srst = wr_ctrl && pwdata[`LPMC_C_CPURST];
    assign dev_srst = wr_ctrl && pwdata[`LPMC_C_DEVRST];

    // ==========================================
    // Wake events
    logic rst_pin;
    logic vdd_ok;
    logic ev_dp;
    logic ev_dm;
    logic ev_ss;
    logic ev_vbus;
    logic cts_lvl;
    logic dev_rst;
    assign rst_pin = !pin_q[`LPMC_P_RSTN];
    assign vdd_ok  = pin_q[`LPMC_P_VDD];
    assign ev_dp   = pin_q[`LPMC_P_DP] ^ prev_q[`LPMC_P_DP];
    assign ev_dm   = pin_q[`LPMC_P_DM] ^ prev_q[`LPMC_P_DM];
    assign ev_ss   = pin_q[`LPMC_P_SS];
    assign ev_vbus = pin_q[`LPMC_P_VBUS] && !prev_q[`LPMC_P_VBUS];
    assign cts_lvl = pin_q[`LPMC_P_CTS] == cts_pol;
    assign dev_rst = rst_pin || dev_srst;                 // RULE18

    // ==========================================
    // Watchdog tick and counter
    logic tick_int;
    logic tick;
    logic wdt_exp;
    assign tick_int = div_q == 9'(`LPMC_WDT_DIV - 1);
    assign tick     = wdt_ext ? (pin_q[`LPMC_P_SLOW] && !prev_q[`LPMC_P_SLOW])
                              : tick_int;                  // RULE15
    assign wdt_exp  = wdt_en && tick && wdt_cnt_q == 16'h0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 9'h000;
        end else if (tick_int) begin
            div_q <= 9'h000;
        end else begin
            div_q <= div_q + 9'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_q <= `LPMC_WDT_LOAD_RST;
        end else if (!wdt_en) begin
            wdt_cnt_q <= wdt_load_q;                       // RULE16
        end else if (apb_wr && paddr == `LPMC_A_WDT_KICK) begin
            wdt_cnt_q <= wdt_load_q;
        end else if (tick) begin
            wdt_cnt_q <= wdt_exp ? wdt_load_q : wdt_cnt_q - 16'h0001;
        end
    end

    // ==========================================
    // Mode sequencer
    logic wake_susp;
    logic wake_stby;
    assign wake_susp = ev_dp || ev_dm || ev_ss || ev_vbus || cts_lvl;  // RULE7
    assign wake_stby = ev_vbus || cts_lvl || (wdt_exp && wdt_wake_en); // RULE10 RULE14

    always_comb begin
        mode_d = mode_q;
        if (dev_rst) begin
            mode_d = ST_NORMAL;
        end else if (!vdd_ok) begin
            mode_d = ST_PWRDN;                             // RULE13
        end else begin
            unique case (mode_q)
                ST_NORMAL: begin
                    if (susp_req) begin
                        mode_d = ST_SUSPEND;
                    end else if (stby_req) begin
                        mode_d = ST_STANDBY;
                    end
                end
                ST_SUSPEND: begin
                    if (wake_susp) begin
                        mode_d = ST_NORMAL;
                    end
                end
                ST_STANDBY: begin
                    if (wake_stby) begin
                        mode_d = ST_NORMAL;
                    end
                end
                ST_PWRDN: begin
                    mode_d = ST_NORMAL;
                end
            endcase
        end
    end

    always_comb begin
        wake_code = `LPMC_W_NONE;
        if (rst_pin) begin
            wake_code = `LPMC_W_RST;
        end else if (mode_q == ST_STANDBY && wdt_exp && wdt_wake_en) begin
            wake_code = `LPMC_W_WDT;
        end else if (mode_q == ST_SUSPEND && ev_dp) begin
            wake_code = `LPMC_W_DP;
        end else if (mode_q == ST_SUSPEND && ev_dm) begin
            wake_code = `LPMC_W_DM;
        end else if (mode_q == ST_SUSPEND && ev_ss) begin
            wake_code = `LPMC_W_SS;
        end else if (ev_vbus) begin
            wake_code = `LPMC_W_VBUS;
        end else if (cts_lvl) begin
            wake_code = `LPMC_W_CTS;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= ST_NORMAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Controls are decoded from the next mode so they line up with mode_q.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        end else begin
            pwr_q.cpu_clk_en    <= mode_d == ST_NORMAL;    // RULE1 RULE2
            pwr_q.pll_en        <= mode_d == ST_NORMAL;    // RULE1 RULE11
            pwr_q.ss_phy_en     <= mode_d == ST_NORMAL || mode_d == ST_SUSPEND;
            pwr_q.ss_u3         <= mode_d == ST_SUSPEND;   // RULE2
            pwr_q.xcvr_en       <= mode_d == ST_NORMAL || mode_d == ST_SUSPEND;
            pwr_q.core_pwr_en   <= mode_d == ST_NORMAL || mode_d == ST_SUSPEND;
            pwr_q.io_hold       <= mode_d == ST_SUSPEND;   // RULE3
            pwr_q.gpio_cfg_keep <= mode_d == ST_SUSPEND || mode_d == ST_STANDBY;
            pwr_q.ram_retain    <= mode_d != ST_PWRDN;     // RULE4 RULE8
            pwr_q.buf_retain    <= mode_d == ST_NORMAL || mode_d == ST_SUSPEND;
        end
    end

    // Suspend exits keep the program counter; standby and supply exits restart it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_rst_q <= 1'b0;
        end else begin
            cpu_rst_q <= !dev_rst && vdd_ok
                      && ((mode_q == ST_STANDBY && wake_stby)  // RULE10 RULE6
                       || (mode_q == ST_PWRDN)
                       || (mode_q == ST_NORMAL && cpu_srst)      // RULE18
                       || (mode_q == ST_NORMAL && wdt_exp && wdt_rst_en)); // RULE14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_rst_q <= 1'b1;
        end else begin
            dev_rst_q <= dev_rst;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_src_q <= `LPMC_W_NONE;
        end else if (mode_q != ST_NORMAL && mode_d == ST_NORMAL) begin
            wake_src_q <= wake_code;                       // RULE19
        end
    end

    // ==========================================
    // Configuration; lost only on device reset or loss of core supply
    logic cfg_clr;
    assign cfg_clr = dev_rst || mode_q == ST_PWRDN;       // RULE13 RULE4 RULE8

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `LPMC_CFG_RST;
        end else if (cfg_clr) begin
            cfg_q <= `LPMC_CFG_RST;
        end else if (wr_ctrl) begin
            cfg_q <= pwdata[`LPMC_C_CFG_HI:`LPMC_C_CFG_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_load_q <= `LPMC_WDT_LOAD_RST;
        end else if (cfg_clr) begin
            wdt_load_q <= `LPMC_WDT_LOAD_RST;
        end else if (apb_wr && paddr == `LPMC_A_WDT_LOAD) begin
            wdt_load_q <= pwdata[15:0];
        end
    end

    // The multiplier keeps its last value when an out-of-range reference is written.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q     <= `LPMC_REF_RST_MHZ;
            mult_q    <= 8'(`LPMC_PLL_OUT_MHZ / `LPMC_REF_RST_MHZ);
            pll_err_q <= 1'b0;
        end else if (cfg_clr) begin
            ref_q     <= `LPMC_REF_RST_MHZ;
            mult_q    <= 8'(`LPMC_PLL_OUT_MHZ / `LPMC_REF_RST_MHZ);
            pll_err_q <= 1'b0;
        end else if (apb_wr && paddr == `LPMC_A_PLL_CFG) begin
            ref_q <= pwdata[5:0];
            if (pwdata[5:0] >= `LPMC_REF_MIN_MHZ && pwdata[5:0] <= `LPMC_REF_MAX_MHZ) begin
                mult_q    <= 8'(`LPMC_PLL_OUT_MHZ / pwdata[5:0]);  // RULE17
                pll_err_q <= 1'b0;
            end else begin
                pll_err_q <= 1'b1;
            end
        end
    end

    // ==========================================
    // Interrupts; a new event wins over a clear in the same cycle
    assign irq_set[`LPMC_I_WAKE] = mode_q != ST_NORMAL && mode_d == ST_NORMAL;
    assign irq_set[`LPMC_I_WDT]  = wdt_exp && wdt_int_en;              // RULE14
    assign irq_set[`LPMC_I_LOST] = dev_rst || mode_q == ST_PWRDN;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 3'h0;
        end else if (apb_wr && paddr == `LPMC_A_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= 3'h0;
        end else if (cfg_clr) begin
            irq_mask_q <= 3'h0;
        end else if (apb_wr && paddr == `LPMC_A_IRQ_MASK) begin
            irq_mask_q <= pwdata[2:0];
        end
    end

    // ==========================================
    // Read data is captured in the setup cycle so the access phase needs no wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (apb_setup) begin
            pslverr_q <= !mapped;
            prdata_q  <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    `LPMC_A_CTRL:     prdata_q <= {22'h0, cfg_q, 4'h0};
                    `LPMC_A_STATUS:   prdata_q <= {25'h0, wake_src_q, 2'h0, mode_q};
                    `LPMC_A_WDT_LOAD: prdata_q <= {16'h0, wdt_load_q};
                    `LPMC_A_WDT_KICK: prdata_q <= {16'h0, wdt_cnt_q};
                    `LPMC_A_PLL_CFG:  prdata_q <= {15'h0, pll_err_q, mult_q, 2'h0, ref_q};
                    `LPMC_A_IRQ_STAT: prdata_q <= {29'h0, irq_stat_q};
                    `LPMC_A_IRQ_MASK: prdata_q <= {29'h0, irq_mask_q};
                    default:          prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign pready      = 1'b1;
    assign prdata      = prdata_q;
    assign pslverr     = pslverr_q && psel && penable;
    assign pwr_o       = pwr_q;
    assign cpu_reset_o = cpu_rst_q;
    assign dev_reset_o = dev_rst_q;
    assign pll_mult_o  = mult_q;
    assign irq_o       = |(irq_stat_q & irq_mask_q);

    // ==========================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_normal_clocks: assert property ( // RULE1
        mode_q == ST_NORMAL |-> pwr_o.cpu_clk_en && pwr_o.pll_en)
        else $error("clocks off in normal mode");
    chk_suspend_clocks: assert property ( // RULE2
        mode_q == ST_SUSPEND |-> !pwr_o.cpu_clk_en && !pwr_o.pll_en && pwr_o.ss_u3)
        else $error("suspend clock state wrong");
    chk_suspend_hold: assert property ( // RULE3
        mode_q == ST_SUSPEND |-> pwr_o.io_hold && pwr_o.ram_retain)
        else $error("suspend not holding pins");
    chk_suspend_retain: assert property ( // RULE4
        mode_q == ST_SUSPEND && !dev_rst && !apb_wr |=> $stable(wdt_load_q))
        else $error("config lost in suspend");
    chk_resume_no_pc: assert property ( // RULE6
        $past(mode_q) == ST_SUSPEND && mode_q == ST_NORMAL |-> !cpu_reset_o)
        else $error("suspend wake reset the core");
    chk_suspend_wake: assert property ( // RULE7
        mode_q == ST_SUSPEND && wake_susp && vdd_ok |=> mode_q == ST_NORMAL)
        else $error("suspend wake missed");
    chk_standby_pc: assert property ( // RULE10
        $past(mode_q) == ST_STANDBY && mode_q == ST_NORMAL && !dev_reset_o |-> cpu_reset_o)
        else $error("standby wake kept pc");
    chk_standby_off: assert property ( // RULE11
        mode_q == ST_STANDBY |-> !pwr_o.pll_en && !pwr_o.xcvr_en && !pwr_o.core_pwr_en)
        else $error("standby left blocks on");
    chk_supply_loss: assert property ( // RULE13
        !vdd_ok && !dev_rst |=> mode_q == ST_PWRDN ##1 cfg_q == `LPMC_CFG_RST)
        else $error("supply loss not handled");
    chk_wdt_reset: assert property ( // RULE14
        mode_q == ST_NORMAL && wdt_exp && wdt_rst_en && !dev_rst && vdd_ok |=> cpu_reset_o)
        else $error("watchdog reset missed");
    chk_wdt_off: assert property ( // RULE16
        !wdt_en |=> wdt_cnt_q == $past(wdt_load_q) && !$rose(irq_stat_q[`LPMC_I_WDT]))
        else $error("disabled watchdog fired");
    chk_dev_reset: assert property ( // RULE18
        dev_srst |=> dev_reset_o && mode_q == ST_NORMAL)
        else $error("device soft reset ignored");

endmodule

`default_nettype wire

// ### sim/lpmc_wake_model.sv
// Model of the wake sources and supply that drive the controller's pin inputs.
`timescale 1ns/1ps
`default_nettype none

module lpmc_wake_model (
    // Clock
    input  wire logic             pclk,
    // Commanded pin levels and slow clock enable
    input  wire logic [6:0]       lvl_i,
    input  wire logic             slow_run_i,
    // Pins seen by the controller
    output lpmc_pkg::lpmc_pins_t  pins_o
);
    import lpmc_pkg::*;

    logic [3:0]  div_q = 4'h0;
    lpmc_pins_t  pins_q = 8'h60;

    assign pins_o = pins_q;

    // The slow clock stands still when idle, so no stray watchdog tick can occur.
    always @(posedge pclk) begin
        div_q <= slow_run_i ? div_q + 4'h1 : 4'h0;
        pins_q <= {div_q[3], lvl_i};
    end
endmodule

`default_nettype wire

// ### sim/tb_top.sv
// Self-checking testbench of the low power mode controller.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import lpmc_pkg::*;

    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic        e;
    } lpmc_row_t;

    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        cpu_reset, dev_reset, irq, slow_run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  lvl;
    logic [7:0]  pll_mult;
    lpmc_pins_t  pins;
    lpmc_pwr_t   pwr;
    int          err_count;
    int          n_checks;
    int          n_cpu;
    int          n_dev;
    int          mark;
    lpmc_row_t   rows [6];

    lpmc_ctrl u_lpmc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pins_i(pins), .pwr_o(pwr), .cpu_reset_o(cpu_reset),
        .dev_reset_o(dev_reset), .pll_mult_o(pll_mult), .irq_o(irq));

    lpmc_wake_model u_lpmc_wake_model (.pclk(pclk), .lvl_i(lvl), .slow_run_i(slow_run),
        .pins_o(pins));

    always #50 pclk = ~pclk;

    // Reset pulses are counted on their own edge, so a check one step later sees them.
    always @(posedge cpu_reset) n_cpu <= n_cpu + 1;
    always @(posedge dev_reset) n_dev <= n_dev + 1;

    // ==========================================
    // Shared tasks
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Setup cycle, then access phase held until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk) n++; while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            err_count++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic wait_state(input logic [10:0] exp);
        int n;
        n = 0;
        while ({pwr, irq} !== exp && n < 400) @(posedge pclk) #1 n++;
        if (n == 400) begin
            err_count++;
            finish_test();
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, slow_run} = 5'h00;
        {paddr, pwdata, lvl} = {12'h000, 32'h0, 7'h60};
        err_count = 0;
        n_checks = 0;
        rows = '{'{12'h000, 32'h0, 1'b0}, '{12'h004, 32'h0, 1'b0}, '{12'h008, 32'h7fff, 1'b0},
                 '{12'h010, 32'h1513, 1'b0}, '{12'h018, 32'h0, 1'b0}, '{12'h01c, 32'h0, 1'b1}};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk) #1 check(pwr, 10'h3b3);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, rows[i].a, 32'h0);
            check(rd, rows[i].d);
            check(err, rows[i].e);
        end
        $display("register reset values done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 12'h000, 32'h11);
            #1 check(pwr, 10'h0ff);
            @(posedge pclk) lvl[i] <= 1'b1;
            wait_state({10'h3b3, 1'b0});
            apb(1'b0, 12'h004, 32'h0);
            check(rd, 32'(i + 1) << 4);
            check(n_cpu, 0);
            @(posedge pclk) lvl[i] <= 1'b0;
            repeat (8) @(posedge pclk);
        end
        $display("suspend wake sources done");
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h50);
        apb(1'b1, 12'h000, 32'h12);
        #1 check(pwr, 10'h006);
        @(posedge pclk) lvl[0] <= 1'b1;
        repeat (10) @(posedge pclk);
        #1 check(pwr, 10'h006);
        @(posedge pclk) lvl[3] <= 1'b1;
        wait_state({10'h3b3, 1'b0});
        check(n_cpu, 1);
        @(posedge pclk) lvl <= 7'h60;
        apb(1'b1, 12'h018, 32'h1);
        #1 check(irq, 1'b1);
        apb(1'b1, 12'h014, 32'h1);
        #1 check(irq, 1'b0);
        $display("standby and interrupt done");
        apb(1'b1, 12'h010, 32'h28);
        apb(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0a28);
        apb(1'b1, 12'h010, 32'h05);
        #1 check(pll_mult, 8'h0a);
        apb(1'b0, 12'h010, 32'h0);
        check(rd, 32'h10a05);
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b1, 12'h018, 32'h2);
        apb(1'b1, 12'h000, 32'h2c0);
        slow_run <= 1'b1;
        repeat (200) @(posedge pclk);
        #1 check(irq, 1'b0);
        apb(1'b1, 12'h000, 32'h2e0);
        wait_state({10'h3b3, 1'b1});
        apb(1'b1, 12'h014, 32'h7);
        apb(1'b1, 12'h018, 32'h0);
        mark = n_cpu;
        apb(1'b1, 12'h000, 32'h2b2);
        #1 check(pwr, 10'h006);
        wait_state({10'h3b3, 1'b0});
        check(n_cpu > mark, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h70);
        mark = n_cpu;
        apb(1'b1, 12'h000, 32'h320);
        repeat (200) @(posedge pclk);
        check(n_cpu > mark, 1'b1);
        $display("watchdog and pll done");
        slow_run <= 1'b0;
        apb(1'b1, 12'h000, 32'h11);
        @(posedge pclk) lvl[5] <= 1'b0;
        wait_state({10'h3b3, 1'b0});
        check(dev_reset, 1'b1);
        @(posedge pclk) lvl[5] <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h60);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        mark = n_dev;
        apb(1'b1, 12'h000, 32'h8);
        repeat (3) @(posedge pclk);
        check(n_dev > mark, 1'b1);
        apb(1'b1, 12'h008, 32'h5);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h5);
        mark = n_cpu;
        @(posedge pclk) lvl[6] <= 1'b0;
        wait_state({10'h000, 1'b0});
        @(posedge pclk) lvl[6] <= 1'b1;
        wait_state({10'h3b3, 1'b0});
        check(n_cpu > mark, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h7fff);
        $display("reset and power-down done");
        finish_test();
    end
endmodule

`default_nettype wire
